// >>> logic/uls_uart_rx_line_status.sv
// uls_uart_rx_line_status: receive line status flags, receive
// buffer/queue, line status interrupt and an AXI4-Lite register slave.
// assumes a receiver on mclk delivering one-cycle character strobes,
// and the raw serial input pin for break detection.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module uls_uart_rx_line_status (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic rxPin,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxParityBit,
  input wire logic rxStopBit,
  input wire logic awvalid,
  output logic awready,
  input wire logic [5:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [5:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic irqOut
);
  // address decode shared by read and write paths
  function automatic logic isMapped(input logic [5:0] a);
    isMapped = (a == uls_pkg::OFF_RXBUF) || (a == uls_pkg::OFF_IEN) ||
      (a == uls_pkg::OFF_CAUSE) || (a == uls_pkg::OFF_LFMT) ||
      (a == uls_pkg::OFF_FCTL) || (a == uls_pkg::OFF_LSR) ||
      (a == uls_pkg::OFF_FRAME) || (a == uls_pkg::OFF_EVST) ||
      (a == uls_pkg::OFF_EVCLR);
  endfunction

  logic rxSync1_q, rxSync2_q;
  logic [15:0] lowCnt_q, lowCnt_d;
  logic brkHeld_q, brkHeld_d, brkEvt;
  logic awHave_q, awHave_d, wHave_q, wHave_d;
  logic [5:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d, rdMux;
  logic doWr, doRd, lsrRd, popRd;
  logic [2:0] ien_q, ien_d, evSt_q, evSt_d;
  logic [7:0] lfmt_q, lfmt_d;
  logic fifoEn_q, fifoEn_d, flush;
  logic [15:0] frame_q, frame_d;
  logic oe_q, oe_d, pe_q, pe_d, fe_q, fe_d, bi_q, bi_d;
  logic qErrFlag_q, qErrFlag_d;
  logic [7:0] qData_q [uls_pkg::Q_DEPTH];
  logic [7:0] qData_d [uls_pkg::Q_DEPTH];
  logic [uls_pkg::Q_DEPTH-1:0] qErr_q, qErr_d;
  logic [3:0] rdPtr_q, rdPtr_d, wrPtr_q, wrPtr_d, wrIdx;
  logic [4:0] count_q, count_d;
  logic push, accept, peNew, feNew, ovNew, errSet, anyErrQ, dataReady;
  logic [7:0] pushData, wlMask, lsrVal, causeVal;
  logic irqOut_d;

  // two-stage synchroniser on the serial input pin
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rxSync1_q <= 1'b1;
      rxSync2_q <= 1'b1;
    end else begin
      rxSync1_q <= rxPin;
      rxSync2_q <= rxSync1_q;
    end
  end

  // low-time counter, one break event per low stretch
  always_comb begin
    brkEvt = !rxSync2_q && !brkHeld_q && (lowCnt_q == frame_q);
    lowCnt_d = lowCnt_q;
    brkHeld_d = brkHeld_q;
    if (rxSync2_q) begin
      lowCnt_d = 16'h0000;
      brkHeld_d = 1'b0;
    end else begin
      if (lowCnt_q != 16'hFFFF) lowCnt_d = lowCnt_q + 16'h0001;
      if (brkEvt) brkHeld_d = 1'b1;
    end
  end

  // character check: word length mask, parity and stop bit
  always_comb begin
    wlMask = 8'hFF >> (3'h3 - {1'b0, lfmt_q[1:0]});
    push = brkEvt | rxValid;
    pushData = brkEvt ? 8'h00 : rxData;
    peNew = rxValid && !brkEvt && lfmt_q[uls_pkg::LFMT_PEN] &&
      ((^(rxData & wlMask) ^ rxParityBit) ==
       lfmt_q[uls_pkg::LFMT_EVEN]);
    feNew = rxValid && !brkEvt && !rxStopBit;
    ovNew = push && (fifoEn_q ? (count_q == uls_pkg::Q_FULL)
                              : (count_q != 5'h00));
    accept = push && !(fifoEn_q && count_q == uls_pkg::Q_FULL);
    errSet = ovNew | peNew | feNew | brkEvt;
    dataReady = count_q != 5'h00;
  end

  // any error still held among valid queue entries
  always_comb begin
    anyErrQ = 1'b0;
    for (int i = 0; i < uls_pkg::Q_DEPTH; i++) begin
      // distance from the read pointer, wrapped in four bits
      if (qErr_q[i] && ({1'b0, 4'(4'(i) - rdPtr_q)} < count_q))
        anyErrQ = 1'b1;
    end
  end

  // receive buffer / queue storage and pointers
  always_comb begin
    qData_d = qData_q;
    qErr_d = qErr_q;
    rdPtr_d = rdPtr_q;
    wrPtr_d = wrPtr_q;
    count_d = count_q;
    wrIdx = fifoEn_q ? wrPtr_q : rdPtr_q;
    if (popRd) begin
      qErr_d[rdPtr_q] = 1'b0;
      if (fifoEn_q) rdPtr_d = rdPtr_q + 4'h1;
      count_d = count_q - 5'h01;
    end
    if (accept) begin
      qData_d[wrIdx] = pushData;
      qErr_d[wrIdx] = peNew | feNew | brkEvt;
      if (fifoEn_q) begin
        wrPtr_d = wrPtr_q + 4'h1;
        count_d = count_d + 5'h01;
      end else begin
        count_d = 5'h01;
      end
    end
    if (flush) begin
      rdPtr_d = 4'h0;
      wrPtr_d = 4'h0;
      count_d = 5'h00;
      qErr_d = '0;
    end
  end

  // line status flags: a new event wins over the read clear
  always_comb begin
    oe_d = ovNew | (oe_q & !lsrRd);
    pe_d = peNew | (pe_q & !lsrRd);
    fe_d = feNew | (fe_q & !lsrRd);
    bi_d = brkEvt | (bi_q & !lsrRd);
    qErrFlag_d = fifoEn_q & ((accept & (peNew | feNew | brkEvt)) |
      (qErrFlag_q & !(lsrRd & !anyErrQ)));
    lsrVal = 8'h00;
    lsrVal[uls_pkg::LSR_DR] = dataReady;
    lsrVal[uls_pkg::LSR_OE] = oe_q;
    lsrVal[uls_pkg::LSR_PE] = pe_q;
    lsrVal[uls_pkg::LSR_FE] = fe_q;
    lsrVal[uls_pkg::LSR_BI] = bi_q;
    lsrVal[uls_pkg::LSR_QERR] = qErrFlag_q;
  end

  // sticky events, interrupt cause and the interrupt level
  always_comb begin
    evSt_d = evSt_q;
    if (doWr && awAddr_q == uls_pkg::OFF_EVCLR && wStrb_q[0])
      evSt_d = evSt_q & ~wData_q[2:0];
    evSt_d[uls_pkg::IEN_RX] = evSt_d[uls_pkg::IEN_RX] | accept;
    evSt_d[uls_pkg::IEN_LS] = evSt_d[uls_pkg::IEN_LS] | errSet;
    evSt_d[1] = 1'b0;
    if (evSt_q[uls_pkg::IEN_LS] && ien_q[uls_pkg::IEN_LS])
      causeVal = uls_pkg::CAUSE_LS;
    else if (evSt_q[uls_pkg::IEN_RX] && ien_q[uls_pkg::IEN_RX])
      causeVal = uls_pkg::CAUSE_RX;
    else
      causeVal = uls_pkg::CAUSE_NONE;
    irqOut_d = |(evSt_q & ien_q);
  end

  // write channel: address and data taken in either order
  always_comb begin
    awAddr_d = awAddr_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    doWr = awHave_q && wHave_q && !bvalid;
    awHave_d = awHave_q;
    wHave_d = wHave_q;
    if (awvalid && awready) begin
      awHave_d = 1'b1;
      awAddr_d = awaddr;
    end
    if (wvalid && wready) begin
      wHave_d = 1'b1;
      wData_d = wdata;
      wStrb_d = wstrb;
    end
    if (doWr) begin
      awHave_d = 1'b0;
      wHave_d = 1'b0;
    end
    awready_d = !awHave_d;
    wready_d = !wHave_d;
    bvalid_d = doWr | (bvalid & !bready);
    bresp_d = bresp;
    if (doWr) bresp_d = isMapped(awAddr_q) ? uls_pkg::RESP_OK
                                           : uls_pkg::RESP_ERR;
  end

  // writable registers, lane 0 for bytes, lanes 0 and 1 for frame
  always_comb begin
    ien_d = ien_q;
    lfmt_d = lfmt_q;
    fifoEn_d = fifoEn_q;
    frame_d = frame_q;
    flush = 1'b0;
    if (doWr && wStrb_q[0]) begin
      unique case (awAddr_q)
        uls_pkg::OFF_IEN: ien_d = {wData_q[2], 1'b0, wData_q[0]};
        uls_pkg::OFF_LFMT: lfmt_d = wData_q[7:0];
        uls_pkg::OFF_FCTL: begin
          fifoEn_d = wData_q[uls_pkg::FCTL_EN];
          flush = fifoEn_d != fifoEn_q;
        end
        uls_pkg::OFF_FRAME: frame_d[7:0] = wData_q[7:0];
        default: ;
      endcase
    end
    if (doWr && wStrb_q[1] && awAddr_q == uls_pkg::OFF_FRAME)
      frame_d[15:8] = wData_q[15:8];
  end

  // read channel with its side effects on the flags and the queue
  always_comb begin
    doRd = arvalid && arready;
    lsrRd = doRd && araddr == uls_pkg::OFF_LSR;
    popRd = doRd && araddr == uls_pkg::OFF_RXBUF && dataReady;
    unique case (araddr)
      uls_pkg::OFF_RXBUF: rdMux = {24'h0, qData_q[rdPtr_q]};
      uls_pkg::OFF_IEN: rdMux = {29'h0, ien_q};
      uls_pkg::OFF_CAUSE: rdMux = {24'h0, causeVal};
      uls_pkg::OFF_LFMT: rdMux = {24'h0, lfmt_q};
      uls_pkg::OFF_FCTL: rdMux = {31'h0, fifoEn_q};
      uls_pkg::OFF_LSR: rdMux = {24'h0, lsrVal};
      uls_pkg::OFF_FRAME: rdMux = {16'h0, frame_q};
      uls_pkg::OFF_EVST: rdMux = {29'h0, evSt_q};
      default: rdMux = 32'h0;
    endcase
    rvalid_d = doRd | (rvalid & !rready);
    arready_d = !rvalid_d;
    rdata_d = doRd ? rdMux : rdata;
    rresp_d = rresp;
    if (doRd) rresp_d = isMapped(araddr) ? uls_pkg::RESP_OK
                                         : uls_pkg::RESP_ERR;
  end

  // register every next value
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lowCnt_q <= 16'h0000;
      brkHeld_q <= 1'b0;
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 6'h00;
      wData_q <= 32'h0;
      wStrb_q <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= uls_pkg::RESP_OK;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= uls_pkg::RESP_OK;
      ien_q <= uls_pkg::IEN_RST;
      lfmt_q <= uls_pkg::LFMT_RST;
      fifoEn_q <= 1'b0;
      frame_q <= uls_pkg::FRAME_RST;
      evSt_q <= 3'h0;
      irqOut <= 1'b0;
      oe_q <= 1'b0;
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      bi_q <= 1'b0;
      qErrFlag_q <= 1'b0;
      qData_q <= '{default: 8'h00};
      qErr_q <= '0;
      rdPtr_q <= 4'h0;
      wrPtr_q <= 4'h0;
      count_q <= 5'h00;
    end else begin
      lowCnt_q <= lowCnt_d;
      brkHeld_q <= brkHeld_d;
      awHave_q <= awHave_d;
      wHave_q <= wHave_d;
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      awready <= awready_d;
      wready <= wready_d;
      bvalid <= bvalid_d;
      bresp <= bresp_d;
      arready <= arready_d;
      rvalid <= rvalid_d;
      rdata <= rdata_d;
      rresp <= rresp_d;
      ien_q <= ien_d;
      lfmt_q <= lfmt_d;
      fifoEn_q <= fifoEn_d;
      frame_q <= frame_d;
      evSt_q <= evSt_d;
      irqOut <= irqOut_d;
      oe_q <= oe_d;
      pe_q <= pe_d;
      fe_q <= fe_d;
      bi_q <= bi_d;
      qErrFlag_q <= qErrFlag_d;
      qData_q <= qData_d;
      qErr_q <= qErr_d;
      rdPtr_q <= rdPtr_d;
      wrPtr_q <= wrPtr_d;
      count_q <= count_d;
    end
  end

  // checks on the flag behaviour
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_brk;
    brkEvt |=> bi_q && dataReady;
  endproperty
  a_brk: assert property (p_brk) else $error("break not flagged");
  property p_lsirq;
    errSet && ien_q[2] && !(doWr && awAddr_q == uls_pkg::OFF_IEN)
      |-> ##2 irqOut;
  endproperty
  a_lsirq: assert property (p_lsirq) else $error("no ls irq");
  property p_fe;
    feNew |=> fe_q ##1 (fe_q || $past(lsrRd));
  endproperty
  a_fe: assert property (p_fe) else $error("framing flag lost");
  property p_pe;
    lsrRd && !peNew |=> !pe_q;
  endproperty
  a_pe: assert property (p_pe) else $error("parity not cleared");
  property p_ovr1;
    push && !fifoEn_q && dataReady |=> oe_q;
  endproperty
  a_ovr1: assert property (p_ovr1) else $error("overrun missed");
  property p_ovr2;
    push && fifoEn_q && count_q == uls_pkg::Q_FULL && !popRd && !flush
      |=> oe_q && $stable(count_q);
  endproperty
  a_ovr2: assert property (p_ovr2) else $error("full overrun");
  property p_oeclr;
    lsrRd && !ovNew |=> !oe_q;
  endproperty
  a_oeclr: assert property (p_oeclr) else $error("overrun held");
  property p_dr;
    accept && !flush |=> dataReady;
  endproperty
  a_dr: assert property (p_dr) else $error("data ready late");
  property p_drclr;
    popRd && count_q == 5'h01 && !push |=> !dataReady;
  endproperty
  a_drclr: assert property (p_drclr) else $error("data ready stuck");
  property p_qerr;
    !fifoEn_q |=> !qErrFlag_q;
  endproperty
  a_qerr: assert property (p_qerr) else $error("queue error w/o fifo");
  property p_biclr;
    lsrRd && !brkEvt |=> !bi_q;
  endproperty
  a_biclr: assert property (p_biclr) else $error("break held");
  c_brk: cover property (brkEvt ##[1:20] lsrRd);
  c_full: cover property (count_q == uls_pkg::Q_FULL && push);
  c_irq: cover property ($rose(irqOut) && causeVal == uls_pkg::CAUSE_LS);
endmodule
`default_nettype wire

// >>> logic/uls_pkg.sv
// uls_pkg: register map, field positions and reset values for the
// receive line status block; shared by design and bench.
package uls_pkg;
  localparam int ADDR_W = 6;
  // register byte addresses
  localparam logic [5:0] OFF_RXBUF = 6'h00;
  localparam logic [5:0] OFF_IEN = 6'h04;
  localparam logic [5:0] OFF_CAUSE = 6'h08;
  localparam logic [5:0] OFF_LFMT = 6'h0C;
  localparam logic [5:0] OFF_FCTL = 6'h10;
  localparam logic [5:0] OFF_LSR = 6'h14;
  localparam logic [5:0] OFF_FRAME = 6'h18;
  localparam logic [5:0] OFF_EVST = 6'h1C;
  localparam logic [5:0] OFF_EVCLR = 6'h20;
  // line_state_reg bits
  localparam int LSR_DR = 0;
  localparam int LSR_OE = 1;
  localparam int LSR_PE = 2;
  localparam int LSR_FE = 3;
  localparam int LSR_BI = 4;
  localparam int LSR_QERR = 7;
  // irq_enable_reg and event status bits
  localparam int IEN_RX = 0;
  localparam int IEN_LS = 2;
  // line_format_reg fields
  localparam int LFMT_PEN = 3;
  localparam int LFMT_EVEN = 4;
  localparam int FCTL_EN = 0;
  // irq_cause_reg codes
  localparam logic [7:0] CAUSE_NONE = 8'h01;
  localparam logic [7:0] CAUSE_LS = 8'h06;
  localparam logic [7:0] CAUSE_RX = 8'h04;
  // reset values
  localparam logic [2:0] IEN_RST = 3'h0;
  localparam logic [7:0] LFMT_RST = 8'h00;
  localparam logic [15:0] FRAME_RST = 16'hFFFF;
  // receive queue
  localparam int Q_DEPTH = 16;
  localparam logic [4:0] Q_FULL = 5'h10;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// >>> verification/uls_rx_source.sv
// uls_rx_source: far-end receiver model, gives character strobes
// and the raw serial input; assumes the bench calls its tasks.
`timescale 1ns/1ps
`default_nettype none
module uls_rx_source (
  input wire logic mclk,
  output logic rxPin,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxParityBit,
  output logic rxStopBit
);
  // idle line high, no strobe
  initial begin
    rxPin = 1'b1;
    rxValid = 1'b0;
    rxData = 8'h00;
    rxParityBit = 1'b0;
    rxStopBit = 1'b1;
  end
  // one-cycle strobe; payload inverted once the strobe is over
  task automatic send(input logic [7:0] d, input logic p, input logic s);
    @(posedge mclk);
    rxValid <= 1'b1;
    rxData <= d;
    rxParityBit <= p;
    rxStopBit <= s;
    @(posedge mclk);
    rxValid <= 1'b0;
    rxData <= ~d;
    rxParityBit <= ~p;
    rxStopBit <= ~s;
  endtask
  // hold the input in spacing for n cycles
  task automatic hold_low(input int n);
    @(posedge mclk);
    rxPin <= 1'b0;
    repeat (n) @(posedge mclk);
    rxPin <= 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> verification/uls_uart_rx_line_status_bench.sv
// uls_uart_rx_line_status_bench: register-level tests of the line
// status block; assumes uls_pkg and the uls_rx_source model.
`timescale 1ns/1ps
`default_nettype none
module uls_uart_rx_line_status_bench;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [5:0] awaddr = 6'h00;
  logic [5:0] araddr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, irqOut;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, val;
  logic rxPin, rxValid, rxParityBit, rxStopBit;
  logic [7:0] rxData;
  int fails = 0;
  int cmp_count = 0;

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  uls_uart_rx_line_status u_dut (
    .mclk(mclk), .reset_n(reset_n), .rxPin(rxPin), .rxValid(rxValid),
    .rxData(rxData), .rxParityBit(rxParityBit), .rxStopBit(rxStopBit),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .irqOut(irqOut)
  );
  uls_rx_source u_src (
    .mclk(mclk), .rxPin(rxPin), .rxValid(rxValid), .rxData(rxData),
    .rxParityBit(rxParityBit), .rxStopBit(rxStopBit)
  );

  // compare and count
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic tally_and_finish();
    if (fails == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // axi4-lite write, address and data offered together
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic got;
    got = 1'b0;
    @(posedge mclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (!got) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        resp = bresp;
        bready <= 1'b0;
        got = 1'b1;
      end
    end
  endtask
  // axi4-lite read
  task automatic rd(input logic [5:0] a);
    logic got;
    got = 1'b0;
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!got) begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        val = rdata;
        resp = rresp;
        rready <= 1'b0;
        got = 1'b1;
      end
    end
  endtask
  // read a register and compare response and data
  task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
    rd(a);
    chk({resp, val}, {uls_pkg::RESP_OK, e});
  endtask
  // let the interrupt settle, then sample it mid-cycle
  task automatic irqchk(input logic e);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk({33'h0, irqOut}, {33'h0, e});
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    rdchk(uls_pkg::OFF_LSR, 32'h00);
    rdchk(uls_pkg::OFF_IEN, 32'h00);
    rdchk(uls_pkg::OFF_CAUSE, 32'h01);
    rdchk(uls_pkg::OFF_FRAME, 32'hFFFF);
    // odd then even parity sense, each with a wrong parity bit
    for (int m = 0; m < 2; m++) begin
      wr(uls_pkg::OFF_LFMT, 32'h0B | (32'(m) << 4));
      u_src.send(8'h5A, m[0], 1'b1);
      rdchk(uls_pkg::OFF_LSR, 32'h05);
      rdchk(uls_pkg::OFF_RXBUF, 32'h5A);
      rdchk(uls_pkg::OFF_LSR, 32'h00);
    end
    // framing error with interrupt raised, masked and cleared
    wr(uls_pkg::OFF_IEN, 32'h04);
    wr(uls_pkg::OFF_EVCLR, 32'h05);
    irqchk(1'b0);
    u_src.send(8'h33, 1'b0, 1'b0);
    irqchk(1'b1);
    rdchk(uls_pkg::OFF_CAUSE, 32'h06);
    rdchk(uls_pkg::OFF_EVST, 32'h05);
    rdchk(uls_pkg::OFF_LSR, 32'h09);
    rdchk(uls_pkg::OFF_LSR, 32'h01);
    wr(uls_pkg::OFF_IEN, 32'h00);
    irqchk(1'b0);
    wr(uls_pkg::OFF_IEN, 32'h04);
    irqchk(1'b1);
    wr(uls_pkg::OFF_EVCLR, 32'h04);
    irqchk(1'b0);
    rdchk(uls_pkg::OFF_RXBUF, 32'h33);
    // overrun without the queue
    u_src.send(8'h11, 1'b0, 1'b1);
    u_src.send(8'h22, 1'b0, 1'b1);
    rdchk(uls_pkg::OFF_LSR, 32'h03);
    rdchk(uls_pkg::OFF_LSR, 32'h01);
    rdchk(uls_pkg::OFF_RXBUF, 32'h22);
    rdchk(uls_pkg::OFF_LSR, 32'h00);
    // queue error bit held while an error entry remains
    wr(uls_pkg::OFF_FCTL, 32'h01);
    u_src.send(8'h44, 1'b0, 1'b0);
    u_src.send(8'h55, 1'b0, 1'b1);
    rdchk(uls_pkg::OFF_LSR, 32'h89);
    rdchk(uls_pkg::OFF_LSR, 32'h81);
    rdchk(uls_pkg::OFF_RXBUF, 32'h44);
    rdchk(uls_pkg::OFF_RXBUF, 32'h55);
    rdchk(uls_pkg::OFF_LSR, 32'h80);
    rdchk(uls_pkg::OFF_LSR, 32'h00);
    // fill the queue past full
    for (int i = 0; i < 17; i++) u_src.send(8'(i), ^8'(i), 1'b1);
    rdchk(uls_pkg::OFF_LSR, 32'h03);
    for (int i = 0; i < 16; i++) rdchk(uls_pkg::OFF_RXBUF, 32'(i));
    rdchk(uls_pkg::OFF_LSR, 32'h00);
    // break: short spacing ignored, long spacing flagged
    wr(uls_pkg::OFF_FCTL, 32'h00);
    wr(uls_pkg::OFF_FRAME, 32'h14);
    u_src.hold_low(12);
    rdchk(uls_pkg::OFF_LSR, 32'h00);
    wr(uls_pkg::OFF_EVCLR, 32'h04);
    irqchk(1'b0);
    u_src.hold_low(40);
    irqchk(1'b1);
    rdchk(uls_pkg::OFF_LSR, 32'h11);
    rdchk(uls_pkg::OFF_LSR, 32'h01);
    rdchk(uls_pkg::OFF_RXBUF, 32'h00);
    // unmapped address on both channels
    rd(6'h3C);
    chk({resp, val}, {uls_pkg::RESP_ERR, 32'h0});
    wr(6'h3C, 32'h0);
    chk({32'h0, resp}, {32'h0, uls_pkg::RESP_ERR});
    tally_and_finish();
  end

  // watchdog against a hung handshake
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
